// file: core/rlyam_chan.sv
// Constants of the relay alarm logic and the per-relay buzzer/timer channel.
// Assumes one 100 MHz clock, an asynchronous active-low reset and a one-second tick.
// Behaviour
// - Address from switches one to five, binary
// - All address switches off gives address 32
// - Frame fill and delay switches change nothing
// - Polarity on: coil energized without alarm
// - Polarity switch n drives relay n only
// - Relay responds to all events mapped
// - Normal mode follows alarm condition exactly
// - Buzzer mode: acknowledge drops relay early
// - Acknowledge ignored before inhibit time elapses
// - Automatic reset after 15 to 900 s
// - Reactivation after 15 to 900 s
// - Nested OR/AND/NOR/NAND equation drives relay
// - Vote: at least x of y events
// - Option counts failure events in vote
// - LED lit exactly while coil energized

// ==========================================================================
// Shared constants
package rlyam_pkg;
	// Clock rate and second tick
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_PERIOD_S = 1;
	localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
	// Station address
	localparam int ADDR_SW_W = 5;
	localparam int ADDR_W = 6;
	localparam logic [ADDR_W-1:0] ADDR_ALL_OFF = 6'h20;
	// Relay count and timer limits in seconds
	localparam int NUM_RELAYS = 8;
	localparam int POL_SW_W = 8;
	localparam int SEC_W = 10;
	localparam logic [SEC_W-1:0] TIME_MAX_S = 10'h384;
	localparam logic [SEC_W-1:0] TIME_MIN_S = 10'h00F;
	// Control source selection
	localparam logic [1:0] CTL_MAP = 2'h0;
	localparam logic [1:0] CTL_EQN = 2'h1;
	localparam logic [1:0] CTL_VOTE = 2'h2;
	// Equation operators
	localparam logic [1:0] OP_OR = 2'h0;
	localparam logic [1:0] OP_AND = 2'h1;
	localparam logic [1:0] OP_NOR = 2'h2;
	localparam logic [1:0] OP_NAND = 2'h3;
	localparam int EQN_LEVELS = 4;
	// Channel states
	typedef enum logic [1:0] {
		RLYAM_IDLE,
		RLYAM_ON,
		RLYAM_HELD
	} rlyam_state_t;
endpackage : rlyam_pkg

// ==========================================================================
// One relay channel: normal or buzzer behaviour with its timers
module rlyam_chan (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Condition and commands
	input wire logic cond_in,
	input wire logic tick_in,
	input wire logic buzzer_in,
	input wire logic ack_in,
	// Timer settings in seconds
	input wire logic [rlyam_pkg::SEC_W-1:0] inhibit_s_in,
	input wire logic auto_en_in,
	input wire logic [rlyam_pkg::SEC_W-1:0] auto_s_in,
	input wire logic react_en_in,
	input wire logic [rlyam_pkg::SEC_W-1:0] react_s_in,
	// Relay state
	output logic active_out
);
	rlyam_pkg::rlyam_state_t state_q, state_d; // Channel state
	logic [rlyam_pkg::SEC_W-1:0] sec_q, sec_d; // Seconds in state
	logic [rlyam_pkg::SEC_W-1:0] inh_eff, auto_eff, react_eff; // Clamped times

	// Clamp settings into their legal ranges
	always_comb begin
		inh_eff = (inhibit_s_in > rlyam_pkg::TIME_MAX_S) ? rlyam_pkg::TIME_MAX_S : inhibit_s_in;
		auto_eff = (auto_s_in > rlyam_pkg::TIME_MAX_S) ? rlyam_pkg::TIME_MAX_S :
			(auto_s_in < rlyam_pkg::TIME_MIN_S) ? rlyam_pkg::TIME_MIN_S : auto_s_in;
		react_eff = (react_s_in > rlyam_pkg::TIME_MAX_S) ? rlyam_pkg::TIME_MAX_S :
			(react_s_in < rlyam_pkg::TIME_MIN_S) ? rlyam_pkg::TIME_MIN_S : react_s_in;
	end

	// Next state and seconds count
	always_comb begin
		state_d = state_q;
		sec_d = sec_q;
		// Count whole seconds, saturating at the longest time
		if (tick_in && (sec_q < rlyam_pkg::TIME_MAX_S)) begin
			sec_d = sec_q + 10'h001;
		end
		case (state_q)
			rlyam_pkg::RLYAM_IDLE: begin
				// New activation restarts the count
				if (cond_in) begin
					state_d = rlyam_pkg::RLYAM_ON;
					sec_d = '0;
				end
			end
			rlyam_pkg::RLYAM_ON: begin
				if (!cond_in) begin
					state_d = rlyam_pkg::RLYAM_IDLE;
				end else if (buzzer_in && ack_in && (sec_q >= inh_eff)) begin
					state_d = rlyam_pkg::RLYAM_HELD;
					sec_d = '0;
				end else if (buzzer_in && auto_en_in && (sec_q >= auto_eff)) begin
					state_d = rlyam_pkg::RLYAM_HELD;
					sec_d = '0;
				end
			end
			rlyam_pkg::RLYAM_HELD: begin
				// Reset while alarm persists
				if (!cond_in) begin
					state_d = rlyam_pkg::RLYAM_IDLE;
				end else if (!buzzer_in || (react_en_in && (sec_q >= react_eff))) begin
					state_d = rlyam_pkg::RLYAM_ON;
					sec_d = '0;
				end
			end
			default: begin
				state_d = rlyam_pkg::RLYAM_IDLE;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= rlyam_pkg::RLYAM_IDLE;
			sec_q <= '0;
		end else begin
			state_q <= state_d;
			sec_q <= sec_d;
		end
	end

	// Relay is active only in the on state
	assign active_out = (state_q == rlyam_pkg::RLYAM_ON);

	// Checks
	property p_normal_follow;
		@(posedge clk_in) disable iff (!rst_n_in)
		(!buzzer_in && cond_in) |=> ##1 active_out || !$past(cond_in, 1) || !cond_in;
	endproperty
	a_normal_follow: assert property (p_normal_follow) else $error("normal relay lost alarm");

	property p_drop;
		@(posedge clk_in) disable iff (!rst_n_in)
		!cond_in |=> !active_out;
	endproperty
	a_drop: assert property (p_drop) else $error("relay active without condition");

	property p_ack_take;
		@(posedge clk_in) disable iff (!rst_n_in)
		(active_out && buzzer_in && cond_in && ack_in && sec_q >= inh_eff) |=> !active_out;
	endproperty
	a_ack_take: assert property (p_ack_take) else $error("acknowledge not taken");

	property p_ack_inhibit;
		@(posedge clk_in) disable iff (!rst_n_in)
		(active_out && cond_in && !auto_en_in && sec_q < inh_eff) |=> active_out;
	endproperty
	a_ack_inhibit: assert property (p_ack_inhibit) else $error("acknowledge taken too early");

	property p_auto;
		@(posedge clk_in) disable iff (!rst_n_in)
		(active_out && buzzer_in && auto_en_in && sec_q >= auto_eff) |=> !active_out;
	endproperty
	a_auto: assert property (p_auto) else $error("automatic reset missed");

	property p_react;
		@(posedge clk_in) disable iff (!rst_n_in)
		(state_q == rlyam_pkg::RLYAM_HELD && cond_in && react_en_in && sec_q >= react_eff)
			|=> active_out;
	endproperty
	a_react: assert property (p_react) else $error("reactivation missed");

	property p_sec_clear;
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(active_out) |-> (sec_q == '0);
	endproperty
	a_sec_clear: assert property (p_sec_clear) else $error("timer not cleared");
endmodule : rlyam_chan

// file: core/rlyam_top.sv
// Relay alarm module logic: address, event control, relay channels, coils and LEDs.
// Assumes synchronous switch and event inputs and acknowledge pulses from the link logic.

// ==========================================================================
// Top level
module rlyam_top #(
	parameter int NUM_RELAYS = rlyam_pkg::NUM_RELAYS,
	parameter int NUM_EVENTS = 32,
	parameter int TICK_CYCLES = rlyam_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Configuration switches
	input wire logic [rlyam_pkg::ADDR_SW_W-1:0] addr_sw_in,
	input wire logic [rlyam_pkg::POL_SW_W-1:0] polarity_sw_in,
	// Detector events, one bit each
	input wire logic [NUM_EVENTS-1:0] event_in,
	input wire logic [NUM_EVENTS-1:0] fail_event_mask_in,
	// Per-relay control selection
	input wire logic [NUM_RELAYS-1:0][1:0] ctl_sel_in,
	input wire logic [NUM_RELAYS-1:0][NUM_EVENTS-1:0] map_mask_in,
	input wire logic [NUM_RELAYS-1:0][3:0][NUM_EVENTS-1:0] eqn_mask_in,
	input wire logic [NUM_RELAYS-1:0][3:0][1:0] eqn_op_in,
	input wire logic [NUM_RELAYS-1:0][NUM_EVENTS-1:0] vote_mask_in,
	input wire logic [NUM_RELAYS-1:0][$clog2(NUM_EVENTS+1)-1:0] vote_x_in,
	input wire logic [NUM_RELAYS-1:0] vote_fail_cnt_in,
	// Per-relay buzzer settings
	input wire logic [NUM_RELAYS-1:0] buzzer_in,
	input wire logic [NUM_RELAYS-1:0] ack_in,
	input wire logic [NUM_RELAYS-1:0][rlyam_pkg::SEC_W-1:0] inhibit_s_in,
	input wire logic [NUM_RELAYS-1:0] auto_en_in,
	input wire logic [NUM_RELAYS-1:0][rlyam_pkg::SEC_W-1:0] auto_s_in,
	input wire logic [NUM_RELAYS-1:0] react_en_in,
	input wire logic [NUM_RELAYS-1:0][rlyam_pkg::SEC_W-1:0] react_s_in,
	// Station address
	output logic [rlyam_pkg::ADDR_W-1:0] station_addr_out,
	// Relay coils and indicators
	output logic [NUM_RELAYS-1:0] coil_out,
	output logic [NUM_RELAYS-1:0] led_out,
	output logic [NUM_RELAYS-1:0] relay_active_out
);
	localparam int CW = $clog2(NUM_EVENTS + 1); // Vote count width

	// ==========================================================================
	// Station address

	logic [rlyam_pkg::ADDR_W-1:0] addr_q, addr_d; // Decoded address

	// Only switches one to five matter; the fill and delay switches are not inputs
	always_comb begin
		addr_d = {1'b0, addr_sw_in};
		if (addr_sw_in == '0) begin
			addr_d = rlyam_pkg::ADDR_ALL_OFF;
		end
	end

	// Address register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr_q <= rlyam_pkg::ADDR_ALL_OFF;
		end else begin
			addr_q <= addr_d;
		end
	end

	assign station_addr_out = addr_q;

	// ==========================================================================
	// One-second tick

	logic [31:0] tick_cnt_q, tick_cnt_d; // Cycles within the second
	logic tick_q, tick_d; // One-cycle tick

	// Divide the clock down to whole seconds
	always_comb begin
		tick_d = 1'b0;
		tick_cnt_d = tick_cnt_q + 32'h00000001;
		if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
			tick_cnt_d = '0;
			tick_d = 1'b1;
		end
	end

	// Tick registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			tick_q <= tick_d;
		end
	end

	// ==========================================================================
	// Helper functions

	// Count set bits
	function automatic logic [CW-1:0] pop_count(input logic [NUM_EVENTS-1:0] v);
		logic [CW-1:0] n;
		n = '0;
		for (int i = 0; i < NUM_EVENTS; i++) begin
			n = n + CW'(v[i]);
		end
		return n;
	endfunction : pop_count

	// One equation level: operator over the previous result and a masked group
	function automatic logic eqn_level(input logic [1:0] op, input logic use_prev,
		input logic prev, input logic [NUM_EVENTS-1:0] ev, input logic [NUM_EVENTS-1:0] m);
		logic any_v;
		logic all_v;
		any_v = (use_prev & prev) | (|(ev & m));
		all_v = (~use_prev | prev) & (&(ev | ~m));
		case (op)
			rlyam_pkg::OP_OR: return any_v;
			rlyam_pkg::OP_AND: return all_v;
			rlyam_pkg::OP_NOR: return ~any_v;
			rlyam_pkg::OP_NAND: return ~all_v;
			default: return 1'b0;
		endcase
	endfunction : eqn_level

	// ==========================================================================
	// Relay channels

	logic [NUM_RELAYS-1:0] cond; // Control condition per relay
	logic [NUM_RELAYS-1:0] active; // Relay activity per relay
	logic [NUM_RELAYS-1:0] coil_q, coil_d; // Coil drive

	genvar r;
	generate
		for (r = 0; r < NUM_RELAYS; r++) begin : g_relay
			logic eqn_res; // Equation result
			logic [NUM_EVENTS-1:0] vote_ev; // Events counted in the vote

			// Nested equation, innermost group first
			always_comb begin
				eqn_res = eqn_level(eqn_op_in[r][0], 1'b0, 1'b0, event_in, eqn_mask_in[r][0]);
				for (int k = 1; k < rlyam_pkg::EQN_LEVELS; k++) begin
					eqn_res = eqn_level(eqn_op_in[r][k], 1'b1, eqn_res, event_in,
						eqn_mask_in[r][k]);
				end
			end

			// Failure events counted only when the option is set
			always_comb begin
				vote_ev = event_in & vote_mask_in[r] &
					~(fail_event_mask_in & {NUM_EVENTS{~vote_fail_cnt_in[r]}});
			end

			// Select the control source
			always_comb begin
				case (ctl_sel_in[r])
					rlyam_pkg::CTL_MAP: cond[r] = |(event_in & map_mask_in[r]);
					rlyam_pkg::CTL_EQN: cond[r] = eqn_res;
					rlyam_pkg::CTL_VOTE: cond[r] = (pop_count(vote_ev) >= vote_x_in[r]);
					default: cond[r] = 1'b0;
				endcase
			end

			// Buzzer and timer channel
			rlyam_chan u_chan (
				.clk_in(clk_in),
				.rst_n_in(rst_n_in),
				.cond_in(cond[r]),
				.tick_in(tick_q),
				.buzzer_in(buzzer_in[r]),
				.ack_in(ack_in[r]),
				.inhibit_s_in(inhibit_s_in[r]),
				.auto_en_in(auto_en_in[r]),
				.auto_s_in(auto_s_in[r]),
				.react_en_in(react_en_in[r]),
				.react_s_in(react_s_in[r]),
				.active_out(active[r])
			);

			// Polarity switch n acts on relay n
			always_comb begin
				coil_d[r] = active[r] ^ polarity_sw_in[r];
			end
		end
	endgenerate

	// Coil registers, de-energized in reset
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			coil_q <= '0;
		end else begin
			coil_q <= coil_d;
		end
	end

	assign coil_out = coil_q;
	assign led_out = coil_q;
	assign relay_active_out = active;

	// ==========================================================================
	// Checks

	property p_addr;
		@(posedge clk_in) disable iff (!rst_n_in)
		(addr_sw_in == '0) |=> (station_addr_out == rlyam_pkg::ADDR_ALL_OFF);
	endproperty
	a_addr: assert property (p_addr) else $error("all-off address not 32");

	property p_addr_bin;
		@(posedge clk_in) disable iff (!rst_n_in)
		(addr_sw_in != '0) |=> (station_addr_out == {1'b0, $past(addr_sw_in)});
	endproperty
	a_addr_bin: assert property (p_addr_bin) else $error("address not binary");

	property p_polarity;
		@(posedge clk_in) disable iff (!rst_n_in)
		1'b1 |=> (coil_out == ($past(active) ^ $past(polarity_sw_in[NUM_RELAYS-1:0])));
	endproperty
	a_polarity: assert property (p_polarity) else $error("coil polarity wrong");

	property p_led;
		@(posedge clk_in) disable iff (!rst_n_in)
		$changed(coil_out) |-> (led_out == coil_out) && $changed(led_out);
	endproperty
	a_led: assert property (p_led) else $error("indicator differs from coil");

	property p_tick;
		@(posedge clk_in) disable iff (!rst_n_in)
		tick_q |-> (tick_cnt_q == '0) ##1 !tick_q;
	endproperty
	a_tick: assert property (p_tick) else $error("second tick malformed");
endmodule : rlyam_top

// file: verif/rlyam_ctrl_model.sv
// Controller model: issues acknowledge pulses to the relay module.
// Assumes inputs change at the falling clock edge, as the bench does.
module rlyam_ctrl_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Address seen and address aimed at
	input wire logic [5:0] station_addr_in,
	input wire logic [5:0] target_in,
	// Acknowledge lines
	output logic [7:0] ack_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================================
	// Acknowledge of one relay, one cycle wide
	initial ack_out = 8'h00;
	task automatic send_ack(input int idx);
		@(negedge clk_in);
		// Only the module at the aimed address answers
		if (rst_n_in && station_addr_in == target_in) begin
			ack_out[idx] = 1'b1;
		end
		@(negedge clk_in);
		ack_out = 8'h00;
	endtask : send_ack
endmodule : rlyam_ctrl_model

// file: verif/test_rlyam_top.sv
// Testbench of the relay alarm logic: address, control modes, buzzer timers.
// Assumes the core package and top, and the controller model beside this file.
module test_rlyam_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================================
	// Signals
	localparam int TK = 10; // Short second
	logic clk_in, rst_n_in;
	logic [4:0] addr_sw;
	logic [7:0] pol_sw, buzzer, auto_en, react_en, vote_fail, ack;
	logic [31:0] ev, fail_mask;
	logic [7:0][1:0] ctl_sel;
	logic [7:0][31:0] map_mask, vote_mask;
	logic [7:0][3:0][31:0] eqn_mask;
	logic [7:0][3:0][1:0] eqn_op;
	logic [7:0][5:0] vote_x;
	logic [7:0][9:0] inh_s, auto_s, react_s;
	logic [5:0] addr_out;
	logic [7:0] coil, led, act;
	int n_errors = 0;
	int n_tests = 0;
	logic exp_b;
	logic [4:0] addr_sw_list [5] = '{5'h00, 5'h01, 5'h09, 5'h10, 5'h1F}; // Switch settings tried
	// ==========================================================================
	// Design and controller model
	rlyam_top #(.TICK_CYCLES(TK)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.addr_sw_in(addr_sw), .polarity_sw_in(pol_sw), .event_in(ev),
		.fail_event_mask_in(fail_mask), .ctl_sel_in(ctl_sel), .map_mask_in(map_mask),
		.eqn_mask_in(eqn_mask), .eqn_op_in(eqn_op), .vote_mask_in(vote_mask),
		.vote_x_in(vote_x), .vote_fail_cnt_in(vote_fail), .buzzer_in(buzzer),
		.ack_in(ack), .inhibit_s_in(inh_s), .auto_en_in(auto_en), .auto_s_in(auto_s),
		.react_en_in(react_en), .react_s_in(react_s), .station_addr_out(addr_out),
		.coil_out(coil), .led_out(led), .relay_active_out(act));
	rlyam_ctrl_model ctrl_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
	// Analog modules own eight addresses each lower down; one eight-relay module at 32
		.station_addr_in(addr_out), .target_in(6'h20), .ack_out(ack));
	// ==========================================================================
	// Clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// ==========================================================================
	// Helpers
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask : cyc
	task automatic tally_and_finish();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish
	// Watchdog against a hung run
	initial begin
		repeat (5000) @(posedge clk_in);
		n_errors++;
		tally_and_finish();
	end
	// ==========================================================================
	// Main sequence
	initial begin
		rst_n_in = 1'b0;
		addr_sw = 5'h00;
		pol_sw = 8'h02; // Relay 1 energized without alarm
		ev = 32'h0000_0000;
		fail_mask = 32'h0000_0020; // Event 5 is a failure
		ctl_sel = '0;
		map_mask = '0;
		eqn_mask = '0;
		eqn_op = '0;
		vote_mask = '0;
		vote_x = '0;
		vote_fail = 8'h00;
		buzzer = 8'h30;
		auto_en = 8'h20;
		react_en = 8'h10;
		inh_s = '0;
		auto_s = '0;
		react_s = '0;
		map_mask[0] = 32'h0000_0003;
		map_mask[1] = 32'h0000_0003;
		ctl_sel[6] = 2'h3; // Unused source, never active
		map_mask[6] = 32'h0000_0002;
		ctl_sel[2] = 2'h1;
		eqn_mask[2][0] = 32'h0000_0003;
		ctl_sel[3] = 2'h2;
		vote_mask[3] = 32'h0000_002C;
		vote_x[3] = 6'h02;
		map_mask[4] = 32'h0000_0010;
		map_mask[5] = 32'h0000_0010;
		inh_s[4] = 10'h003;
		react_s[4] = 10'h00F;
		auto_s[5] = 10'h00F;
		cyc(5);
		chk("addr in reset", 8'h20, {2'h0, addr_out});
		chk("coil in reset", 8'h00, coil);
		rst_n_in = 1'b1;
		// Address switches, all off meaning 32
		foreach (addr_sw_list[i]) begin
			addr_sw = addr_sw_list[i];
			cyc(2);
			chk("address", (addr_sw == 5'h00) ? 8'h20 : {3'h0, addr_sw}, {2'h0, addr_out});
		end
		addr_sw = 5'h00;
		cyc(3);
		chk("coil polarity idle", 8'h02, coil & 8'h03);
		chk("led idle", 8'h02, led & 8'h03);
		// Map mode, second event alone drives both relays
		ev = 32'h0000_0002;
		cyc(3);
		chk("map active", 8'h03, act & 8'h43);
		chk("coil polarity alarm", 8'h01, coil & 8'h03);
		chk("led", 8'h01, led & 8'h03);
		ctrl_u.send_ack(0);
		cyc(2);
		chk("normal ignores ack", 8'h01, act & 8'h01);
		// Equation, each operator over events 0 and 1 = 01
		ev = 32'h0000_0001;
		for (int op = 0; op < 4; op++) begin
			eqn_op[2][0] = op[1:0];
			cyc(3);
			exp_b = (op == 0 || op == 3);
			chk("equation", {7'h0, exp_b}, {7'h0, act[2]});
		end
		// Second level ANDs event 2 onto the first group
		eqn_op[2][0] = 2'h0;
		eqn_mask[2][1] = 32'h0000_0004;
		eqn_op[2][1] = 2'h1;
		cyc(3);
		chk("equation nested low", 8'h00, {7'h0, act[2]});
		ev = 32'h0000_0005;
		cyc(3);
		chk("equation nested high", 8'h01, {7'h0, act[2]});
		ev = 32'h0000_0000;
		cyc(3);
		chk("map released", 8'h00, act & 8'h03);
		// Vote two of three, failure counted or not
		ev = 32'h0000_0024;
		cyc(3);
		chk("vote fail ignored", 8'h00, {7'h0, act[3]});
		vote_fail[3] = 1'b1;
		cyc(3);
		chk("vote fail counted", 8'h01, {7'h0, act[3]});
		ev = 32'h0000_000C;
		vote_fail[3] = 1'b0;
		cyc(3);
		chk("vote two alarms", 8'h01, {7'h0, act[3]});
		// Buzzer relays 4 and 5 on event 4
		ev = 32'h0000_0010;
		cyc(3);
		chk("buzzer active", 8'h30, act & 8'h30);
		cyc(7);
		ctrl_u.send_ack(4);
		cyc(1);
		chk("ack inhibited", 8'h10, act & 8'h10);
		cyc(38);
		ctrl_u.send_ack(4);
		cyc(1);
		chk("ack taken", 8'h00, act & 8'h10);
		cyc(1);
		chk("coil after ack", 8'h00, coil & 8'h10);
		chk("led after ack", 8'h00, led & 8'h10);
		cyc(75);
		chk("auto still on", 8'h20, act & 8'h20);
		cyc(40);
		chk("auto reset", 8'h00, act & 8'h20);
		cyc(14);
		chk("react not yet", 8'h00, act & 8'h10);
		cyc(40);
		chk("reactivated", 8'h10, act & 8'h10);
		tally_and_finish();
	end
endmodule : test_rlyam_top
